// file: dms_addr_sel.sv
`include "dms_map.svh"
module dms_addr_sel #(
  parameter int unsigned ONCHIP_BYTES = `DMS_ONCHIP
) (
  dms_addr_if.sel ai // Addressing mode in, address and routing out.
);
  import dms_pkg::*;

  dms_addr_t ptr;

  // Pointer choice follows the select bit.
  assign ptr = ai.psel ? ai.dp1 : ai.dp0;
  // Register-indirect takes the high byte from the port 2 latch.
  assign ai.addr = ai.use_ri ? {ai.p2_val, ai.ri_val} : ptr;
  // Anything at or above the on-chip top goes off-chip.
  assign ai.ext = ({1'b0, ai.addr} >= 17'(ONCHIP_BYTES));
endmodule

// file: dms_ctrl.sv
`include "dms_map.svh"
module dms_ctrl #(
  parameter int unsigned ONCHIP_BYTES = `DMS_ONCHIP
) (
  input  wire logic          sys_clk,    // Oscillator clock.
  input  wire logic          rst_b,      // Synchronous reset, low.
  input  wire logic          clk_en,     // Freezes all state when low.
  input  wire dms_pkg::dms_byte_t sfr_addr,  // Register address.
  input  wire dms_pkg::dms_byte_t sfr_wdata, // Register write data.
  input  wire logic          sfr_wr,     // Register write strobe.
  input  wire logic          sfr_rd,     // Register read strobe.
  output dms_pkg::dms_byte_t sfr_rdata,  // Register read data.
  input  wire logic          xfer_req,   // Start a data move.
  input  wire logic          xfer_wr,    // Move is a write.
  input  wire logic          xfer_ri,    // Register-indirect mode.
  input  wire dms_pkg::dms_byte_t ri_val,    // Working register value.
  input  wire dms_pkg::dms_byte_t p2_latch,  // Port 2 latch value.
  input  wire dms_pkg::dms_addr_t dptr0,     // First data pointer.
  input  wire dms_pkg::dms_addr_t dptr1,     // Second data pointer.
  input  wire dms_pkg::dms_addr_t fetch_addr, // Opcode fetch address.
  input  wire dms_pkg::dms_byte_t xfer_wdata, // Data to write.
  output logic               xfer_busy,  // Move in progress.
  output logic               xfer_done,  // Move finished, one clock.
  output dms_pkg::dms_byte_t xfer_rdata, // Data read.
  output logic               ale,        // Address latch strobe.
  output logic               psen_b,     // Program read strobe, low.
  output logic               rd_b,       // Data read strobe, low.
  output logic               wr_b,       // Data write strobe, low.
  output dms_pkg::dms_byte_t p0_out,     // Port 0 output value.
  output logic               p0_oe,      // Port 0 driven.
  input  wire dms_pkg::dms_byte_t p0_in,     // Port 0 pin level.
  output dms_pkg::dms_byte_t p2_out,     // Port 2 output value.
  output dms_pkg::dms_addr_t int_addr,   // On-chip memory address.
  output logic               int_rd,     // On-chip read strobe.
  output logic               int_wr,     // On-chip write strobe.
  output dms_pkg::dms_byte_t int_wdata,  // On-chip write data.
  input  wire dms_pkg::dms_byte_t int_rdata  // On-chip read data.
);
  import dms_pkg::*;

  // Strobe start, counted in clocks from the data ALE clock.
  function automatic logic [5:0] str_start(input dms_stretch_t s);
    return (s == 3'h0) ? 6'h01 : 6'h02;
  endfunction

  // Strobe width; stretch zero is the odd one, not four per step.
  function automatic logic [5:0] str_len(input dms_stretch_t s);
    return (s == 3'h0) ? 6'h02 : {1'b0, s, 2'b00};
  endfunction

  // Clocks in the whole instruction: stretch plus two cycles.
  function automatic logic [5:0] ins_clks(input dms_stretch_t s);
    return {1'b0, s, 2'b00} + (`DMS_MC_CLKS << 1);
  endfunction

  dms_phase_if ph ();
  dms_addr_if  ai ();

  dms_phase u_phase (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .ph      (ph)
  );

  dms_addr_sel #(.ONCHIP_BYTES(ONCHIP_BYTES)) u_addr (
    .ai (ai)
  );

  dms_byte_t    ccr_r;
  logic         psel_r;
  dms_state_t   st_r;
  logic [5:0]   cnt_r;
  dms_stretch_t stl_r;
  logic         wr_l_r;
  logic         ext_l_r;
  dms_addr_t    addr_l_r;
  dms_byte_t    wdat_l_r;

  // Address selection runs off the live pointers and select bit.
  assign ai.use_ri = xfer_ri;
  assign ai.ri_val = ri_val;
  assign ai.p2_val = p2_latch;
  assign ai.dp0    = dptr0;
  assign ai.dp1    = dptr1;
  assign ai.psel   = psel_r;

  // Register decode; only the two owned addresses answer.
  logic ccr_hit;
  logic psel_hit;
  dms_stretch_t str_set;
  assign ccr_hit  = (sfr_addr == `DMS_CCR_ADDR);
  assign psel_hit = (sfr_addr == `DMS_PSEL_ADDR);
  assign str_set  = ccr_r[`DMS_STR_MSB:`DMS_STR_LSB];

  // Whole byte is stored, so upper bits survive stretch updates.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ccr_r  <= `DMS_CCR_RST;
      psel_r <= `DMS_PSEL_RST;
    end else if (clk_en && sfr_wr) begin
      if (ccr_hit) begin
        ccr_r <= sfr_wdata;
      end
      if (psel_hit) begin
        psel_r <= sfr_wdata[`DMS_PSEL_BIT];
      end
    end
  end

  // Read mux; other pointer-select bits read as zero.
  dms_byte_t rd_nxt;
  always_comb begin
    rd_nxt = 8'h00;
    if (ccr_hit) begin
      rd_nxt = ccr_r;
    end else if (psel_hit) begin
      rd_nxt = {7'h00, psel_r};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sfr_rdata <= 8'h00;
    end else if (clk_en && sfr_rd) begin
      sfr_rdata <= rd_nxt;
    end
  end

  // A move starts only on a machine-cycle boundary.
  logic go;
  logic run;
  logic last;
  assign run  = (st_r == DMS_RUN);
  assign go   = !run && xfer_req && ph.mc_end;
  assign last = run && (cnt_r == ins_clks(stl_r) - 6'h01);

  // Sequencer; stretch, mode and address are frozen per move, so a
  // rewrite mid-move only touches the next one.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_r     <= DMS_IDLE;
      cnt_r    <= 6'h00;
      stl_r    <= 3'h0;
      wr_l_r   <= 1'b0;
      ext_l_r  <= 1'b0;
      addr_l_r <= 16'h0000;
      wdat_l_r <= 8'h00;
    end else if (clk_en) begin
      case (st_r)
        DMS_IDLE: begin
          if (go) begin
            st_r     <= DMS_RUN;
            cnt_r    <= 6'h00;
            stl_r    <= str_set;
            wr_l_r   <= xfer_wr;
            ext_l_r  <= ai.ext;
            addr_l_r <= ai.addr;
            wdat_l_r <= xfer_wdata;
          end
        end
        DMS_RUN: begin
          cnt_r <= cnt_r + 6'h01;
          if (last) begin
            st_r <= DMS_IDLE;
          end
        end
        default: st_r <= DMS_IDLE;
      endcase
    end
  end

  // Clock index inside the data part of the move.
  logic       fet;
  logic [5:0] dc;
  logic       strb;
  assign fet  = run && (cnt_r < `DMS_MC_CLKS);
  assign dc   = cnt_r - `DMS_MC_CLKS;
  // Strobe sits after the setup clocks, one at stretch zero and two otherwise; stretch also sets its width.
  assign strb = run && !fet && (dc >= str_start(stl_r)) &&
                (dc < str_start(stl_r) + str_len(stl_r));

  // Fetch cycle is fixed: ALE at clock 0, program read at 1 and 2.
  logic ale_nxt;
  logic psen_nxt;
  assign ale_nxt  = run && ((cnt_r == 6'h00) ||
                    (!fet && ext_l_r && dc == 6'h00));
  assign psen_nxt = fet && (cnt_r == 6'h01 || cnt_r == 6'h02);

  // Port 0 carries address first, then write data through hold.
  logic      p0oe_nxt;
  dms_byte_t p0_nxt;
  dms_byte_t p2_nxt;
  assign p0oe_nxt = run && ((cnt_r == 6'h00) ||
                    (!fet && ext_l_r && (dc == 6'h00 || wr_l_r)));
  assign p0_nxt   = (cnt_r == 6'h00) ? fetch_addr[7:0] :
                    (dc == 6'h00) ? addr_l_r[7:0] : wdat_l_r;
  assign p2_nxt   = fet ? fetch_addr[15:8] :
                    run ? addr_l_r[15:8] : p2_latch;

  // Read data is taken while the strobe output is still active.
  logic cap;
  assign cap = run && !fet && !wr_l_r &&
               (dc == str_start(stl_r) + str_len(stl_r));

  // All pins and handshakes come straight from flip-flops.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ale    <= 1'b0;
      psen_b <= 1'b1;
      rd_b   <= 1'b1;
      wr_b   <= 1'b1;
      p0_oe  <= 1'b0;
      p0_out <= 8'h00;
      p2_out <= 8'h00;
    end else if (clk_en) begin
      ale    <= ale_nxt;
      psen_b <= !psen_nxt;
      rd_b   <= !(strb && ext_l_r && !wr_l_r);
      wr_b   <= !(strb && ext_l_r && wr_l_r);
      p0_oe  <= p0oe_nxt;
      p0_out <= p0_nxt;
      p2_out <= p2_nxt;
    end
  end

  // On-chip accesses get the same strobe timing; only their high address byte reaches a pin, on port 2.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      int_rd    <= 1'b0;
      int_wr    <= 1'b0;
      int_addr  <= 16'h0000;
      int_wdata <= 8'h00;
    end else if (clk_en) begin
      int_rd    <= strb && !ext_l_r && !wr_l_r;
      int_wr    <= strb && !ext_l_r && wr_l_r;
      int_addr  <= addr_l_r;
      int_wdata <= wdat_l_r;
    end
  end

  // Handshake back to the core.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      xfer_busy  <= 1'b0;
      xfer_done  <= 1'b0;
      xfer_rdata <= 8'h00;
    end else if (clk_en) begin
      xfer_busy <= (run && !last) || go;
      xfer_done <= last;
      if (cap) begin
        xfer_rdata <= ext_l_r ? p0_in : int_rdata;
      end
    end
  end

  // Helper counters for the checks below; they only move with clk_en.
  logic       sto;
  logic [5:0] str_w_r;
  logic [5:0] since_ale_r;
  logic [5:0] ins_w_r;
  assign sto = !rd_b || !wr_b || int_rd || int_wr;
  // On-chip moves have no data ALE, so the data cycle's first pin clock
  // restarts the set-up count as well.
  logic dstart;
  assign dstart = run && (cnt_r == `DMS_MC_CLKS + 6'h01);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      str_w_r     <= 6'h00;
      since_ale_r <= 6'h00;
      ins_w_r     <= 6'h00;
    end else if (clk_en) begin
      str_w_r     <= sto ? str_w_r + 6'h01 : 6'h00;
      since_ale_r <= (ale || dstart) ? 6'h01 : since_ale_r + 6'h01;
      ins_w_r     <= xfer_busy ? ins_w_r + 6'h01 : 6'h00;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  quarter_wrap_a: assert property (
    clk_en && ph.mc_end |=> ph.quarter == 2'h0)
    else $error("machine cycle is not four clocks");

  one_access_a: assert property (
    !(!psen_b && sto))
    else $error("fetch and data strobes overlap");

  stretch_rst_a: assert property (
    @(posedge sys_clk) disable iff (1'b0)
    !rst_b |=> ccr_r == `DMS_CCR_RST)
    else $error("stretch not one after reset");

  strobe_width_a: assert property (
    $fell(sto) |-> str_w_r == str_len(stl_r))
    else $error("strobe width wrong for stretch");

  strobe_setup_a: assert property (
    $rose(sto) |-> since_ale_r == str_start(stl_r))
    else $error("strobe set-up wrong for stretch");

  instr_len_a: assert property (
    $rose(xfer_done) |-> ins_w_r == ins_clks(stl_r))
    else $error("instruction length wrong");

  fetch_fixed_a: assert property (
    $fell(psen_b) |-> since_ale_r == 6'h01 ##1 !psen_b)
    else $error("fetch timing changed");

  onchip_quiet_a: assert property (
    run && !ext_l_r |-> rd_b && wr_b)
    else $error("on-chip access reached the pins");

  sfr_readback_a: assert property (
    clk_en && sfr_wr && ccr_hit ##1 !sfr_wr ##1
    clk_en && sfr_rd && ccr_hit && !sfr_wr
    |=> sfr_rdata == $past(sfr_wdata, 3))
    else $error("clock control read-back differs");

  full_speed_c: cover property (xfer_done && stl_r == 3'h0 && ext_l_r);
  slowest_c: cover property (xfer_done && stl_r == 3'h7 && wr_l_r);
  onchip_rd_c: cover property ($fell(int_rd) && xfer_busy);
  ptr_two_c: cover property (go && psel_r && !xfer_ri);
endmodule

// file: dms_ctrl_tb.sv
module dms_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dms_pkg::*;
  logic       sys_clk, rst_b, sfr_wr, sfr_rd, xfer_req, xfer_wr, xfer_ri;
  logic       xfer_busy, xfer_done, ale, psen_b, rd_b, wr_b, p0_oe;
  logic       int_rd, int_wr, clk_en;
  dms_byte_t  wv;
  logic [4:0] lat;
  dms_byte_t  sfr_addr, sfr_wdata, sfr_rdata, ri_val, p2_latch, xfer_wdata;
  dms_byte_t  xfer_rdata, p0_out, p0_in, p2_out, int_wdata, int_rdata, d;
  dms_addr_t  dptr0, dptr1, int_addr, wa;
  int         miscompares, n_compared, cyc, sl, xl, pl, al, sf, sv, av, tick;

  // A 40 ns oscillator clock.
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  dms_ctrl u_dut (.sys_clk, .rst_b, .clk_en, .sfr_addr, .sfr_wdata,
    .sfr_wr, .sfr_rd, .sfr_rdata, .xfer_req, .xfer_wr, .xfer_ri, .ri_val,
    .p2_latch, .dptr0, .dptr1, .fetch_addr(16'h2468), .xfer_wdata,
    .xfer_busy, .xfer_done, .xfer_rdata, .ale, .psen_b, .rd_b, .wr_b,
    .p0_out, .p0_oe, .p0_in, .p2_out, .int_addr, .int_rd, .int_wr,
    .int_wdata, .int_rdata);

  dms_sram u_mem (.sys_clk, .ale, .rd_b, .wr_b, .p0_oe, .p0_out, .p2_out,
    .lat, .p0_in);

  // On-chip memory returns a pattern derived from its address.
  assign int_rdata = int_addr[7:0] ^ 8'h5A;

  // Measure each move at mid-cycle, where registered outputs are settled.
  always @(negedge sys_clk) begin
    tick++;
    if (tick > 5000) begin
      miscompares++;
      $display("Error at %0t: run did not finish", $time);
      conclude();
    end else if (xfer_busy === 1'b1 && clk_en) begin
      // A frozen clock repeats the previous state, so it is not counted.
      if (!psen_b) pl++;
      if (ale) begin
        al++;
        av = cyc;
      end
      if (!rd_b || !wr_b) xl++;
      if (!rd_b || !wr_b || int_rd || int_wr) begin
        if (sl == 0) sf = cyc;
        sl++;
        sv = cyc;
      end
      if (int_wr) {wa, wv} = {int_addr, int_wdata};
      cyc++;
    end
  end

  task automatic chk(input dms_byte_t got, input int exp);
    n_compared++;
    if (got !== 8'(exp)) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, 8'(exp));
    end
  endtask

  task automatic sfr_w(input dms_byte_t a, input dms_byte_t v);
    @(posedge sys_clk);
    sfr_addr  <= a;
    sfr_wdata <= v;
    sfr_wr    <= 1'b1;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
  endtask

  task automatic sfr_r(input dms_byte_t a, input int exp);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
    @(negedge sys_clk);
    chk(sfr_rdata, exp);
  endtask

  // One move; the unused address sources carry a wrong address on purpose.
  task automatic move(input logic w, ri, ps, input dms_addr_t a,
                      input dms_byte_t wd);
    int n;
    @(posedge sys_clk);
    {cyc, sl, xl, pl, al} = '0;
    xfer_req   <= 1'b1;
    xfer_wr    <= w;
    xfer_ri    <= ri;
    xfer_wdata <= wd;
    {p2_latch, ri_val} <= ri ? a : ~a;
    dptr0 <= (ri || ps) ? ~a : a;
    dptr1 <= (!ri && ps) ? a : ~a;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (xfer_busy !== 1'b1 && n < 20);
    @(posedge sys_clk);
    xfer_req <= 1'b0;
    n = 0;
    while (xfer_done !== 1'b1 && n < 60) begin
      @(negedge sys_clk);
      n++;
    end
    if (xfer_done !== 1'b1) begin
      miscompares++;
      $display("Error at %0t: move did not finish", $time);
    end
    d = xfer_rdata;
  endtask

  // Cycle count, strobe width, set-up, hold, fetch and latch pulses.
  task automatic timing(input int s, input logic ext);
    chk(8'(cyc), 4 * (s + 2));
    chk(8'(sl), (s == 0) ? 2 : 4 * s);
    // On-chip moves have no data ALE; their data cycle opens one machine
    // cycle after the fetch ALE.
    chk(8'(sf - av - (ext ? 0 : 4)), (s == 0) ? 1 : 2);
    // The last strobe clock of a move is the last busy cycle at stretch zero, and the one before it otherwise.
    chk(8'(cyc - sv), (s == 0) ? 1 : 2);
    chk(8'(pl), 2);
    chk(8'(al), ext ? 2 : 1);
    chk(8'(xl), ext ? sl : 0);
  endtask

  task automatic conclude;
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Main sequence: registers, every stretch, on-chip, pointers, indirect.
  initial begin
    {rst_b, sfr_wr, sfr_rd, xfer_req, xfer_wr, xfer_ri} = '0;
    {sfr_addr, sfr_wdata, ri_val, p2_latch, xfer_wdata} = '0;
    {dptr0, dptr1} = '0;
    clk_en = 1'b1;
    lat = 5'h04;
    {miscompares, n_compared, tick} = '0;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    sfr_r(8'h8E, 8'h01);
    move(1'b0, 1'b0, 1'b0, 16'h0400, 8'h00);
    timing(1, 1'b1);
    sfr_r(8'h86, 8'h00);
    sfr_w(8'h86, 8'hFF);
    sfr_r(8'h86, 8'h01);
    sfr_w(8'h86, 8'h00);
    sfr_w(8'h8F, 8'h33);
    sfr_r(8'h8F, 8'h00);
    sfr_r(8'h8E, 8'h01);
    for (int s = 0; s < 8; s++) begin
      sfr_w(8'h8E, {5'h15, 3'(s)});
      sfr_r(8'h8E, {5'h15, 3'(s)});
      lat <= (s == 0) ? 5'h02 : 5'(4 * s);
      move(1'b1, 1'b0, 1'b0, 16'(16'h0400 + s * 16'h0111),
           8'(8'h3C ^ s));
      timing(s, 1'b1);
      move(1'b0, 1'b0, 1'b0, 16'(16'h0400 + s * 16'h0111), 8'h00);
      timing(s, 1'b1);
      chk(d, 8'h3C ^ s);
    end
    sfr_w(8'h8E, 8'h02);
    move(1'b0, 1'b0, 1'b0, 16'h03FF, 8'h00);
    timing(2, 1'b0);
    chk(d, 8'hFF ^ 8'h5A);
    move(1'b1, 1'b0, 1'b0, 16'h0123, 8'hA5);
    timing(2, 1'b0);
    chk(wv, 8'hA5);
    chk(wa[15:8], 8'h01);
    chk(wa[7:0], 8'h23);
    lat <= 5'h08;
    sfr_w(8'h86, 8'h01);
    // A short freeze inside a move must leave every measured figure alone.
    fork
      move(1'b1, 1'b0, 1'b1, 16'h1234, 8'hC3);
      begin
        repeat (9) @(posedge sys_clk);
        clk_en <= 1'b0;
        repeat (3) @(posedge sys_clk);
        clk_en <= 1'b1;
      end
    join
    timing(2, 1'b1);
    sfr_w(8'h86, 8'h00);
    move(1'b0, 1'b0, 1'b0, 16'h1234, 8'h00);
    chk(d, 8'hC3);
    move(1'b0, 1'b1, 1'b0, 16'h0400, 8'h00);
    chk(d, 8'h3C);
    conclude();
  end
endmodule

// file: dms_if.sv
// Machine-cycle phase shared between the phase counter and the sequencer.
interface dms_phase_if;
  logic [1:0] quarter;
  logic       mc_end;
  modport gen (output quarter, output mc_end);
  modport use_ph (input quarter, input mc_end);
endinterface

// Address selection request and result.
interface dms_addr_if;
  import dms_pkg::*;
  logic      use_ri;
  dms_byte_t ri_val;
  dms_byte_t p2_val;
  dms_addr_t dp0;
  dms_addr_t dp1;
  logic      psel;
  dms_addr_t addr;
  logic      ext;
  modport host (output use_ri, output ri_val, output p2_val,
                output dp0, output dp1, output psel,
                input addr, input ext);
  modport sel (input use_ri, input ri_val, input p2_val,
               input dp0, input dp1, input psel,
               output addr, output ext);
endinterface

// file: dms_map.svh
`ifndef DMS_MAP_SVH
`define DMS_MAP_SVH

// Special-function addresses decoded by this block.
`define DMS_CCR_ADDR  8'h8E
`define DMS_PSEL_ADDR 8'h86

// Reset values: stretch of one, first data pointer selected.
`define DMS_CCR_RST   8'h01
`define DMS_PSEL_RST  1'b0

// Stretch field position inside the clock control register.
`define DMS_STR_MSB   2
`define DMS_STR_LSB   0

// Pointer select bit position inside its register.
`define DMS_PSEL_BIT  0

// Oscillator clocks in one machine cycle, and its last quarter.
`define DMS_MC_CLKS   6'h04
`define DMS_Q_LAST    2'h3

// Default size of on-chip data memory in bytes.
`define DMS_ONCHIP    1024

`endif

// file: dms_phase.sv
`include "dms_map.svh"
module dms_phase (
  input wire logic sys_clk, // Oscillator clock.
  input wire logic rst_b,   // Synchronous reset, active low.
  input wire logic clk_en,  // Freezes the count while low.
  dms_phase_if.gen ph       // Quarter of the machine cycle.
);
  import dms_pkg::*;

  logic [1:0] q_r;

  // Four oscillator clocks make one machine cycle.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      q_r <= 2'h0;
    end else if (clk_en) begin
      q_r <= q_r + 2'h1;
    end
  end

  assign ph.quarter = q_r;
  assign ph.mc_end  = (q_r == `DMS_Q_LAST);
endmodule

// file: dms_pkg.sv
package dms_pkg;

  // One byte of the special-function space or of the bus.
  typedef logic [7:0] dms_byte_t;

  // A 16-bit data-memory address.
  typedef logic [15:0] dms_addr_t;

  // The 3-bit stretch setting.
  typedef logic [2:0] dms_stretch_t;

  // Sequencer state.
  typedef enum logic {
    DMS_IDLE = 1'b0,
    DMS_RUN  = 1'b1
  } dms_state_t;

endpackage

// file: dms_sram.sv
// External SRAM on the multiplexed bus; lat sets its access time in clocks.
module dms_sram (
  input  wire logic               sys_clk, // Oscillator clock.
  input  wire logic               ale,     // Address latch strobe.
  input  wire logic               rd_b,    // Read strobe, low.
  input  wire logic               wr_b,    // Write strobe, low.
  input  wire logic               p0_oe,   // Controller drives port 0.
  input  wire dms_pkg::dms_byte_t p0_out,  // Controller port 0 value.
  input  wire dms_pkg::dms_byte_t p2_out,  // High address byte.
  input  wire logic [4:0]         lat,     // Strobe clocks before data.
  output dms_pkg::dms_byte_t      p0_in    // Resolved port 0 level.
);
  import dms_pkg::*;
  dms_byte_t  mem [0:65535];
  dms_byte_t  lo_r;
  dms_byte_t  last_r = 8'h00;
  logic [4:0] cnt_r = 5'h00;
  dms_addr_t  addr;
  logic       drv;

  // Data only appears once the strobe has lasted lat clocks; before that
  // the released bus shows a changing pattern, so a short strobe reads junk.
  assign addr  = {p2_out, lo_r};
  assign drv   = !rd_b && (cnt_r + 5'h01 >= lat);
  assign p0_in = p0_oe ? p0_out : (drv ? mem[addr] : ~last_r);

  // Latch the low address, count strobe clocks and store written data.
  always @(posedge sys_clk) begin
    last_r <= p0_in;
    if (ale) lo_r <= p0_in;
    cnt_r <= rd_b ? 5'h00 : cnt_r + 5'h01;
    if (!wr_b) mem[addr] <= p0_in;
  end
endmodule
